// >>> verilog/qspc_pkg.sv
// shared constants, types and field layout for the quad serial port control block
`default_nettype none
package qspc_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // geometry
   localparam int CHAN_COUNT = 4;
   localparam int WORD_W = 8;

   ////////////////////////////////////////////////////////////////////////////
   // host i/o addresses
   localparam logic [7:0] CHAN_BASE_ADDR = 8'hd0;
   localparam logic [7:0] CHAN_ADDR_SPAN = 8'h08;
   localparam logic [7:0] IRQ_STAT_ADDR = 8'hd8;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'hd9;
   localparam logic [7:0] PPORT_ADDR = 8'he9;
   localparam int PPORT_CHAN_RST_BIT = 4;

   ////////////////////////////////////////////////////////////////////////////
   // mode word and command word fields
   localparam int MODE_ASYNC_LSB = 0;
   localparam logic [1:0] MODE_SYNC_CODE = 2'h0;
   localparam int MODE_SINGLE_SYNC_BIT = 7;
   localparam int CMD_SOFT_RESET_BIT = 6;

   ////////////////////////////////////////////////////////////////////////////
   // status word fields
   localparam int STAT_TX_READY_BIT = 0;
   localparam int STAT_RX_READY_BIT = 1;
   localparam int STAT_CMD_PHASE_BIT = 2;
   localparam int STAT_SYNC_MODE_BIT = 3;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] PPORT_RESET = 8'h00;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
   localparam logic [7:0] WORD_RESET = 8'h00;
   // request levels after reset: every transmitter empty and ready, nothing received
   localparam logic [7:0] REQ_PREV_RESET = 8'haa;

   typedef enum logic [1:0] {
      PH_MODE,
      PH_SYNC1,
      PH_SYNC2,
      PH_CMD
   } qspc_phase_e;

   typedef struct packed {
      qspc_phase_e phase;
      logic [7:0] mode;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] cmd;
      logic tx_full;
      logic [7:0] tx_char;
      logic rx_full;
      logic [7:0] rx_char;
   } qspc_chan_s;

   // phase PH_MODE is the first enum value, so all-zero is the reset state
   localparam qspc_chan_s CHAN_RESET = '0;

   // toward the serial engine of one channel
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] cmd;
      logic configured;
      logic tx_valid;
      logic [7:0] tx_char;
   } qspc_line_s;
endpackage : qspc_pkg
`default_nettype wire

// >>> verilog/qspc_irq.sv
// sticky interrupt status with write-one-to-clear and a mask onto one level output
`default_nettype none
module qspc_irq #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] events,
   input wire logic stat_wr,
   input wire logic mask_wr,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] stat,
   output logic [WIDTH-1:0] mask,
   output logic irq
);
   typedef struct packed {
      logic [WIDTH-1:0] stat;
      logic [WIDTH-1:0] mask;
   } qspc_irq_s;

   qspc_irq_s cur;
   qspc_irq_s next_cur;

   always_comb
   begin
      next_cur = cur;
      if (stat_wr)
      begin
         next_cur.stat = cur.stat & ~wdata;
      end
      // an event in the clearing cycle is kept
      next_cur.stat = next_cur.stat | events;
      if (mask_wr)
      begin
         next_cur.mask = wdata;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         cur.stat <= '0;
         cur.mask <= WIDTH'(qspc_pkg::IRQ_MASK_RESET);
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign stat = cur.stat;
   assign mask = cur.mask;
   assign irq = |(cur.stat & cur.mask);
endmodule : qspc_irq
`default_nettype wire

// >>> verilog/qspc_top.sv
// quad serial port control: host i/o decode, channel init sequencing, ready flags
//
// What this block does
// - after any reset the first control write is taken as the mode word.
// - mode word selects sync or async, deciding whether sync characters follow.
// - in sync operation one or two following control writes are stored as sync patterns.
// - second sync slot skipped for single sync; both skipped in async.
// - after mode and sync words every control write is a command word.
// - command with bit 6 set returns that channel to awaiting a mode word.
// - channel control/status ports sit at d1, d3, d5 and d7.
// - bit 4 of the parallel port at e9 resets all four channels together.
// - data address read returns received character; write loads transmit character.
// - transmit-ready set while a character can be accepted, cleared by data write.
// - receive-ready set when a character arrives, cleared by data read.
// - both ready flags drive interrupt requests and appear in the status word.
// - reading a channel's upper address returns that channel's status word.
// - each channel has two addresses: lower for data, upper for control and status.
//
// The address map and the address-and-strobe port were decided locally.
`default_nettype none
module qspc_top (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   output qspc_pkg::qspc_line_s [3:0] line_out,
   input wire logic [3:0] tx_pull,
   input wire logic [3:0] rx_push,
   input wire logic [3:0][7:0] rx_char,
   output logic [7:0] pport_out,
   output logic [7:0] int_request,
   output logic irq
);
   typedef struct packed {
      qspc_pkg::qspc_chan_s [3:0] ch;
      logic [7:0] pport;
      logic [7:0] rdata;
      logic [7:0] req_prev;
   } qspc_top_s;

   qspc_top_s cur;
   qspc_top_s next_cur;

   logic [7:0] req_level;
   logic [7:0] req_events;
   logic [7:0] irq_stat;
   logic [7:0] irq_mask;
   logic irq_stat_wr;
   logic irq_mask_wr;

   ////////////////////////////////////////////////////////////////////////////
   // address decode helpers

   // true when the address falls in the eight channel addresses
   function automatic logic chan_hit(input logic [7:0] addr);
      logic [7:0] offs;
      offs = addr - qspc_pkg::CHAN_BASE_ADDR;
      chan_hit = (addr >= qspc_pkg::CHAN_BASE_ADDR) && (offs < qspc_pkg::CHAN_ADDR_SPAN);
   endfunction : chan_hit

   // channel number from an address inside the channel range
   function automatic logic [1:0] chan_idx(input logic [7:0] addr);
      logic [7:0] offs;
      offs = addr - qspc_pkg::CHAN_BASE_ADDR;
      chan_idx = offs[2:1];
   endfunction : chan_idx

   // odd address is the control/status port, even is data
   function automatic logic chan_upper(input logic [7:0] addr);
      chan_upper = addr[0];
   endfunction : chan_upper

   // status word of one channel
   function automatic logic [7:0] status_word(input qspc_pkg::qspc_chan_s c);
      logic [7:0] s;
      s = 8'h00;
      s[qspc_pkg::STAT_TX_READY_BIT] = ~c.tx_full;
      s[qspc_pkg::STAT_RX_READY_BIT] = c.rx_full;
      s[qspc_pkg::STAT_CMD_PHASE_BIT] = (c.phase == qspc_pkg::PH_CMD);
      s[qspc_pkg::STAT_SYNC_MODE_BIT] = is_sync(c.mode) && (c.phase != qspc_pkg::PH_MODE);
      status_word = s;
   endfunction : status_word

   // async field zero selects synchronous operation
   function automatic logic is_sync(input logic [7:0] mode);
      is_sync = (mode[qspc_pkg::MODE_ASYNC_LSB +: 2] == qspc_pkg::MODE_SYNC_CODE);
   endfunction : is_sync

   ////////////////////////////////////////////////////////////////////////////
   // request levels, ordered rx0, tx0, rx1, tx1 ... as the interrupt unit expects

   always_comb
   begin
      req_level = 8'h00;
      for (int i = 0; i < qspc_pkg::CHAN_COUNT; i++)
      begin
         req_level[2*i] = cur.ch[i].rx_full;
         req_level[2*i+1] = ~cur.ch[i].tx_full;
      end
   end

   // a flag rising is the event that latches a sticky status bit
   assign req_events = req_level & ~cur.req_prev;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      logic [1:0] sel;
      logic hit;
      logic upper;
      logic board_rst;
      sel = chan_idx(bus_addr);
      hit = chan_hit(bus_addr);
      upper = chan_upper(bus_addr);
      board_rst = cur.pport[qspc_pkg::PPORT_CHAN_RST_BIT];
      next_cur = cur;
      next_cur.req_prev = req_level;
      next_cur.rdata = 8'h00;
      irq_stat_wr = 1'b0;
      irq_mask_wr = 1'b0;

      // serial engine side
      for (int i = 0; i < qspc_pkg::CHAN_COUNT; i++)
      begin
         if (tx_pull[i])
         begin
            next_cur.ch[i].tx_full = 1'b0;
         end
         if (rx_push[i])
         begin
            next_cur.ch[i].rx_full = 1'b1;
            next_cur.ch[i].rx_char = rx_char[i];
         end
      end

      // host writes
      if (bus_wr)
      begin
         // channel ports decoded at d0 to d7
         if (hit && !upper)
         begin
            next_cur.ch[sel].tx_char = bus_wdata;
            next_cur.ch[sel].tx_full = 1'b1;
         end
         else if (hit && upper)
         begin
            case (cur.ch[sel].phase)
               qspc_pkg::PH_MODE:
               begin
                  // first control write is the mode word
                  next_cur.ch[sel].mode = bus_wdata;
                  if (is_sync(bus_wdata))
                  begin
                     next_cur.ch[sel].phase = qspc_pkg::PH_SYNC1;
                  end
                  else
                  begin
                     next_cur.ch[sel].phase = qspc_pkg::PH_CMD;
                  end
               end
               qspc_pkg::PH_SYNC1:
               begin
                  next_cur.ch[sel].sync1 = bus_wdata;
                  if (cur.ch[sel].mode[qspc_pkg::MODE_SINGLE_SYNC_BIT])
                  begin
                     next_cur.ch[sel].phase = qspc_pkg::PH_CMD;
                  end
                  else
                  begin
                     next_cur.ch[sel].phase = qspc_pkg::PH_SYNC2;
                  end
               end
               qspc_pkg::PH_SYNC2:
               begin
                  next_cur.ch[sel].sync2 = bus_wdata;
                  next_cur.ch[sel].phase = qspc_pkg::PH_CMD;
               end
               default:
               begin
                  // soft reset ignores the other bits
                  if (bus_wdata[qspc_pkg::CMD_SOFT_RESET_BIT])
                  begin
                     next_cur.ch[sel] = qspc_pkg::CHAN_RESET;
                  end
                  else
                  begin
                     // every later control write is a command
                     next_cur.ch[sel].cmd = bus_wdata;
                  end
               end
            endcase
         end
         else if (bus_addr == qspc_pkg::PPORT_ADDR)
         begin
            next_cur.pport = bus_wdata;
         end
         else if (bus_addr == qspc_pkg::IRQ_STAT_ADDR)
         begin
            irq_stat_wr = 1'b1;
         end
         else if (bus_addr == qspc_pkg::IRQ_MASK_ADDR)
         begin
            irq_mask_wr = 1'b1;
         end
      end

      // host reads; answer stands only in the following cycle
      if (bus_rd)
      begin
         if (hit && !upper)
         begin
            next_cur.rdata = cur.ch[sel].rx_char;
            // flag drops on read unless a new character lands now
            if (!rx_push[sel])
            begin
               next_cur.ch[sel].rx_full = 1'b0;
            end
         end
         else if (hit && upper)
         begin
            next_cur.rdata = status_word(cur.ch[sel]);
         end
         else if (bus_addr == qspc_pkg::PPORT_ADDR)
         begin
            next_cur.rdata = cur.pport;
         end
         else if (bus_addr == qspc_pkg::IRQ_STAT_ADDR)
         begin
            next_cur.rdata = irq_stat;
         end
         else if (bus_addr == qspc_pkg::IRQ_MASK_ADDR)
         begin
            next_cur.rdata = irq_mask;
         end
         else
         begin
            next_cur.rdata = 8'h00;
         end
      end

      // all channels held in reset while the port bit is set
      if (board_rst)
      begin
         for (int i = 0; i < qspc_pkg::CHAN_COUNT; i++)
         begin
            next_cur.ch[i] = qspc_pkg::CHAN_RESET;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < qspc_pkg::CHAN_COUNT; i++)
         begin
            // reset returns to awaiting the mode word
            cur.ch[i] <= qspc_pkg::CHAN_RESET;
         end
         cur.pport <= qspc_pkg::PPORT_RESET;
         cur.rdata <= 8'h00;
         // empty transmitters after reset count as already ready, no event
         cur.req_prev <= qspc_pkg::REQ_PREV_RESET;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status and mask

   qspc_irq #(
      .WIDTH(8)
   ) u_irq (
      .sys_clk(sys_clk),
      .srst(srst),
      .events(req_events),
      .stat_wr(irq_stat_wr),
      .mask_wr(irq_mask_wr),
      .wdata(bus_wdata),
      .stat(irq_stat),
      .mask(irq_mask),
      .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   always_comb
   begin
      for (int i = 0; i < qspc_pkg::CHAN_COUNT; i++)
      begin
         line_out[i].mode = cur.ch[i].mode;
         line_out[i].sync1 = cur.ch[i].sync1;
         line_out[i].sync2 = cur.ch[i].sync2;
         line_out[i].cmd = cur.ch[i].cmd;
         // the engine must not act on a half-programmed channel
         line_out[i].configured = (cur.ch[i].phase == qspc_pkg::PH_CMD);
         line_out[i].tx_valid = cur.ch[i].tx_full;
         line_out[i].tx_char = cur.ch[i].tx_char;
      end
   end

   assign bus_rdata = cur.rdata;
   assign pport_out = cur.pport;
   // levels toward the priority interrupt unit
   assign int_request = req_level;
endmodule : qspc_top
`default_nettype wire

// >>> test/qspc_top_properties.sv
// port-level assertions for the quad serial port control block
`default_nettype none
module qspc_top_chk (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire qspc_pkg::qspc_line_s [3:0] line_out,
   input wire logic [3:0] tx_pull,
   input wire logic [3:0] rx_push,
   input wire logic [3:0][7:0] rx_char,
   input wire logic [7:0] pport_out,
   input wire logic [7:0] int_request,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   logic run;
   // channels are held in reset while the board reset bit is set
   assign run = !pport_out[4];

   AST_RDATA_ONE_CYCLE: assert property (
      !$past(bus_rd) |-> bus_rdata == 8'h00) else $error("read data outside read slot");
   AST_STATUS_FLAGS: assert property (
      bus_rd && bus_addr == 8'hd1 |=> bus_rdata[0] == $past(int_request[1])
      && bus_rdata[1] == $past(int_request[0])) else $error("status flag bits wrong");
   AST_TX_TAKE: assert property (
      bus_wr && bus_addr == 8'hd6 && run |=> line_out[3].tx_valid && !int_request[7]
      && line_out[3].tx_char == $past(bus_wdata)) else $error("data write not taken");
   AST_RX_SET: assert property (
      rx_push[1] && run |=> int_request[2]) else $error("receive flag not set");
   AST_RX_CLEAR: assert property (
      bus_rd && bus_addr == 8'hd2 && !rx_push[1] |=> !int_request[2])
      else $error("receive flag not cleared");
   AST_TX_LEVEL: assert property (
      int_request[1] == !line_out[0].tx_valid) else $error("tx request mismatch");
   AST_SOFT_RESET: assert property (
      line_out[2].configured && bus_wr && bus_addr == 8'hd5 && bus_wdata[6] && run
      |=> !line_out[2].configured && line_out[2].mode == 8'h00) else $error("soft reset");
   AST_BOARD_RESET: assert property (
      pport_out[4] |=> !line_out[1].configured && int_request == 8'haa)
      else $error("board reset not held");
   AST_PPORT_WRITE: assert property (
      bus_wr && bus_addr == 8'he9 |=> pport_out == $past(bus_wdata))
      else $error("port write lost");
   AST_CMD_STORE: assert property (
      line_out[0].configured && bus_wr && bus_addr == 8'hd1 && !bus_wdata[6] && run
      |=> line_out[0].cmd == $past(bus_wdata) && line_out[0].configured)
      else $error("command not stored");
endmodule : qspc_top_chk

bind qspc_top qspc_top_chk chk (.sys_clk, .srst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
   .bus_rdata, .line_out, .tx_pull, .rx_push, .rx_char, .pport_out, .int_request, .irq);
`default_nettype wire

// >>> test/qspc_engine_model.sv
// behavioural serial engines on the far side of the four channels
`default_nettype none
module qspc_engine_model (
   input wire logic sys_clk,
   input wire logic srst,
   input wire qspc_pkg::qspc_line_s [3:0] line_out,
   input wire logic [3:0] stall,
   output logic [3:0] tx_pull,
   output logic [3:0] rx_push,
   output logic [3:0][7:0] rx_char,
   output logic tx_seen,
   output logic [7:0] tx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hit;
   logic [3:0] nxt;

   initial
   begin
      tx_pull = 4'h0;
      rx_push = 4'h0;
      rx_char = '0;
      tx_seen = 1'b0;
      tx_data = 8'h00;
   end

   // one character per cycle; stall keeps a channel from taking
   always @(posedge sys_clk)
   begin
      hit = 1'b0;
      nxt = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         if (!srst && !hit && line_out[i].tx_valid && !stall[i] && !tx_pull[i])
         begin
            hit = 1'b1;
            nxt[i] = 1'b1;
            tx_data <= line_out[i].tx_char;
         end
      end
      tx_pull <= nxt;
      tx_seen <= hit;
   end

   // received byte is valid with the push only; inverted afterwards
   task automatic send_rx(input int ch, input logic [7:0] c);
      rx_push[ch] <= 1'b1;
      rx_char[ch] <= c;
      @(posedge sys_clk);
      rx_push[ch] <= 1'b0;
      rx_char[ch] <= ~c;
   endtask : send_rx
endmodule : qspc_engine_model
`default_nettype wire

// >>> test/tb_quad_serial_port_control.sv
// self-checking bench for the quad serial port control block
`default_nettype none
module tb_quad_serial_port_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, srst, bus_wr, bus_rd, rd_q, tx_seen, irq, s;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, pport_out, int_request, tx_data, a, c;
   logic [3:0] tx_pull, rx_push, stall;
   logic [3:0][7:0] rx_char;
   qspc_pkg::qspc_line_s [3:0] line_out;
   logic [7:0] rq[$];
   logic [7:0] tq[$];
   logic [7:0] md [4] = '{8'h4e, 8'h8c, 8'h4f, 8'h0c};
   int err_count, n_compared;

   qspc_top dut (.sys_clk, .srst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
      .line_out, .tx_pull, .rx_push, .rx_char, .pport_out, .int_request, .irq);
   qspc_engine_model eng (.sys_clk, .srst, .line_out, .stall, .tx_pull, .rx_push,
      .rx_char, .tx_seen, .tx_data);

   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      bus_wr <= 1'b1;
      bus_addr <= ad;
      bus_wdata <= d;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
      @(posedge sys_clk);
   endtask : wr

   task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
      rq.push_back(exp);
      bus_rd <= 1'b1;
      bus_addr <= ad;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      @(posedge sys_clk);
   endtask : rd

   task automatic wait_req(input int b, input logic v);
      int i;
      for (i = 0; i < 50 && int_request[b] !== v; i++)
         @(posedge sys_clk);
      if (i == 50)
      begin
         err_count++;
         finish_test();
      end
   endtask : wait_req

   // a read result stands only in the cycle after its strobe
   always @(posedge sys_clk)
   begin
      rd_q <= bus_rd;
      if (rd_q && rq.size() > 0)
         cmp("rdata", rq.pop_front(), bus_rdata);
      if (tx_seen && tq.size() > 0)
         cmp("tx char", tq.pop_front(), tx_data);
   end

   initial
   begin
      srst = 1'b1;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      stall = 4'h0;
      rd_q = 1'b0;
      err_count = 0;
      n_compared = 0;
      void'($urandom(32'h7d9a75e9));
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      // pulse bit 4, other port bits kept
      wr(8'he9, 8'h2b);
      wr(8'he9, 8'h3b);
      wr(8'hd1, 8'h4e);
      wr(8'he9, 8'h2b);
      rd(8'he9, 8'h2b);
      rd(8'hd1, 8'h01);
      rd(8'he0, 8'h00);
      $display("test board_reset done");
      // irq mask left clear during init
      for (int n = 0; n < 4; n++)
      begin
         a = 8'hd1 + 8'(2 * n);
         s = md[n][1:0] == 2'h0;
         wait_req(2 * n + 1, 1'b1);
         wr(a, md[n]);
         rd(a, {4'h0, s, !s, 2'h1});
         if (s)
         begin
            wr(a, 8'h16);
            if (!md[n][7])
            begin
               rd(a, 8'h09);
               wr(a, 8'h61);
            end
         end
         wr(a, 8'h37);
         rd(a, {4'h0, s, 3'h5});
         cmp("mode", md[n], line_out[n].mode);
         cmp("sync1", s ? 8'h16 : 8'h00, line_out[n].sync1);
         cmp("sync2", (s && !md[n][7]) ? 8'h61 : 8'h00, line_out[n].sync2);
         cmp("cmd", 8'h37, line_out[n].cmd);
      end
      $display("test init done");
      stall <= 4'hf;
      for (int n = 0; n < 4; n++)
      begin
         a = 8'hd1 + 8'(2 * n);
         s = md[n][1:0] == 2'h0;
         c = 8'($urandom);
         tq.push_back(c);
         wr(a - 8'h01, c);
         rd(a, {4'h0, s, 3'h4});
         stall[n] <= 1'b0;
         wait_req(2 * n + 1, 1'b1);
         c = 8'($urandom);
         eng.send_rx(n, c);
         rd(a, {4'h0, s, 3'h7});
         rd(a - 8'h01, c);
         rd(a, {4'h0, s, 3'h5});
      end
      $display("test data done");
      wr(8'hd9, 8'h01);
      wr(8'hd8, 8'hff);
      cmp("irq", 8'h00, {7'h0, irq});
      eng.send_rx(0, 8'h5a);
      repeat (2) @(posedge sys_clk);
      cmp("irq", 8'h01, {7'h0, irq});
      rd(8'hd8, 8'h01);
      rd(8'hd9, 8'h01);
      rd(8'hd0, 8'h5a);
      wr(8'hd8, 8'h01);
      cmp("irq", 8'h00, {7'h0, irq});
      wr(8'hd9, 8'h00);
      eng.send_rx(0, 8'ha5);
      repeat (2) @(posedge sys_clk);
      cmp("irq", 8'h00, {7'h0, irq});
      rd(8'hd8, 8'h01);
      rd(8'hd0, 8'ha5);
      $display("test irq done");
      // soft reset only in command phase
      wr(8'hd5, 8'h40);
      rd(8'hd5, 8'h01);
      cmp("cfg", 8'h00, {7'h0, line_out[2].configured});
      wr(8'hd5, 8'h4f);
      rd(8'hd5, 8'h05);
      wr(8'hd5, 8'h15);
      cmp("cmd", 8'h15, line_out[2].cmd);
      $display("test soft_reset done");
      finish_test();
   end
endmodule : tb_quad_serial_port_control
`default_nettype wire
